// ---- include/lin_flags_pkg.sv ----
// Package of constants and carriers for the LIN status flag block
package lin_flags_pkg;

  // Register offsets on the plain register port
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_DATA = 4'h1;
  localparam logic [3:0] ADDR_CTRL = 4'h2;
  localparam logic [3:0] ADDR_IRQ_EN = 4'h3;

  // Status bit positions
  localparam int BIT_TX_EMPTY = 7;
  localparam int BIT_TX_DONE = 6;
  localparam int BIT_RX_FULL = 5;
  localparam int BIT_IDLE = 4;
  localparam int BIT_HDR_ERR = 3;
  localparam int BIT_NOISE = 2;
  localparam int BIT_FRAME_ERR = 1;
  localparam int BIT_PARITY_ERR = 0;

  // Control bit positions
  localparam int CTL_LIN_MODE = 0;
  localparam int CTL_SLAVE_SELECT = 1;
  localparam int CTL_RX_MUTE = 2;
  localparam int CTL_HDR_DETECT_METHOD = 3;
  localparam int CTL_PARITY_CHECK_EN = 4;
  localparam int CTL_SYNCH_STATE = 5;

  // Reset values
  localparam logic [7:0] STATUS_RESET = 8'hc0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] IRQ_EN_RESET = 8'h00;

  // Dominant bits needed to rejoin a busy bus
  localparam logic [3:0] HOTPLUG_BITS = 4'hb;

  // Hot plug hunt states
  typedef enum logic [1:0] {
    HP_OFF = 2'b00,
    HP_HUNT = 2'b01,
    HP_DONE = 2'b11
  } hp_state_e;

  // Receive side events from the serial engine
  typedef struct packed {
    logic rx_done;
    logic rx_is_break;
    logic stop_dominant;
    logic any_recessive;
    logic noise;
    logic id_parity_bad;
    logic in_header;
    logic header_timeout;
    logic synch_corrupt;
    logic idle_line;
    logic id_detected;
  } rx_evt_s;

  // Transmit side events
  typedef struct packed {
    logic buf_to_shift;
    logic char_done;
    logic char_is_data;
  } tx_evt_s;

endpackage

// ---- rtl/lin_hotplug.sv ----
// Hot plug hunt for eleven consecutive dominant bits
`timescale 1ns/100ps
`default_nettype none
module lin_hotplug
  import lin_flags_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Mode
  input wire logic hunt_en,
  // Bit stream
  input wire logic bit_tick,
  input wire logic rx_pin,
  // Result
  output logic discard
);

  hp_state_e state_q;
  logic [3:0] run_q;

  // Hunt state; a released enable rearms the hunt
  always_ff @(posedge mclk)
  begin
    if (reset || !hunt_en)
    begin
      state_q <= HP_OFF;
      run_q <= 4'h0;
    end
    else
    begin
      case (state_q)
        HP_OFF:
        begin
          state_q <= HP_HUNT;
          run_q <= 4'h0;
        end
        HP_HUNT:
          if (bit_tick)
          begin
            if (rx_pin)
              run_q <= 4'h0;
            else if (run_q == HOTPLUG_BITS - 4'h1)
              state_q <= HP_DONE;
            else
              run_q <= run_q + 4'h1;
          end
        default:
          state_q <= HP_DONE;
      endcase
    end
  end

  // Bits before the run are thrown away
  assign discard = hunt_en && (state_q != HP_DONE);

endmodule // lin_hotplug
`default_nettype wire

// ---- rtl/lin_status_flags.sv ----
// LIN status flags, clear sequences, interrupt and hot plug
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - In LIN slave mute mode bits are dropped until eleven dominant bits.
// - The status register reads C0h after reset.
// - tx_empty sets on buffer to shift move and clears by status then write.
// - tx_done sets after a data character, never after a break.
// - rx_full sets on received data and clears by status then data read.
// - idle sets on idle line and not again until rx_full has set.
// - header_error sets on corrupt synch, header time-out or overrun.
// - header_error interrupts on rx_irq_en; clearing it needs the synch state clear.
// - Outside the header header_error reports ordinary overrun.
// - noise_flag acts in master mode and carries no meaning in slave mode.
// - frame_error in slave mode needs dominant stop and a recessive bit.
// - A break never sets frame_error; header_detect_flag reports it when the header detect method is zero.
// - parity_error sets on identifier parity fault when checking enabled.
// - In mute a framing error on a non break character is dropped.
// - A slave leaves mute on break or identifier per the detect method.
module lin_status_flags
  import lin_flags_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Serial engine events
  input wire tx_evt_s tx_evt,
  input wire rx_evt_s rx_evt,
  input wire logic [7:0] rx_byte,
  input wire logic bit_tick,
  input wire logic rx_pin,
  // Towards the engine
  output logic [7:0] tx_byte,
  output logic tx_load,
  output logic rx_discard,
  output logic header_detect_flag,
  // Interrupt
  output logic irq
);

  logic [7:0] status_q;
  logic [7:0] ctrl_q;
  logic [7:0] irq_en_q;
  logic [7:0] data_q;
  logic [7:0] armed_q;
  logic [7:0] rdata_q;
  logic idle_block_q;
  logic hdr_flag_q;
  logic lin_mode;
  logic slave;
  logic mute;
  logic slave_mute;
  logic status_acc;
  logic data_rd;
  logic data_wr;
  logic rx_ok;
  logic frame_bad;
  logic real_frame;
  logic hunt_drop;
  logic [7:0] set_v;
  logic [7:0] clr_v;

  // Control decode
  assign lin_mode = ctrl_q[CTL_LIN_MODE];
  assign slave = ctrl_q[CTL_SLAVE_SELECT];
  assign mute = ctrl_q[CTL_RX_MUTE];
  assign slave_mute = lin_mode && slave && mute;

  // Bus strobes
  assign status_acc = (rd || wr) && (addr == ADDR_STATUS);
  assign data_rd = rd && (addr == ADDR_DATA);
  assign data_wr = wr && (addr == ADDR_DATA);

  // Hot plug hunt
  lin_hotplug u_hotplug (
    .mclk(mclk),
    .reset(reset),
    .hunt_en(slave_mute),
    .bit_tick(bit_tick),
    .rx_pin(rx_pin),
    .discard(hunt_drop)
  );
  assign rx_discard = hunt_drop;

  // Receive qualification; muted or hunting characters are dropped
  assign rx_ok = rx_evt.rx_done && !hunt_drop && !mute;
  assign frame_bad = rx_evt.stop_dominant && rx_evt.any_recessive;
  // Slave mode demands a genuine framing error; break never counts
  assign real_frame = rx_evt.rx_done && !hunt_drop && !rx_evt.rx_is_break
    && !mute
    && (slave ? frame_bad : rx_evt.stop_dominant);

  // Set terms for each flag
  always_comb
  begin
    set_v = 8'h00;
    set_v[BIT_TX_EMPTY] = tx_evt.buf_to_shift;
    set_v[BIT_TX_DONE] = tx_evt.char_done && tx_evt.char_is_data;
    set_v[BIT_RX_FULL] = rx_ok && !rx_evt.rx_is_break;
    set_v[BIT_IDLE] = rx_evt.idle_line && !idle_block_q;
    // Overrun in or out of header, plus header faults
    set_v[BIT_HDR_ERR] = (rx_ok && status_q[BIT_RX_FULL])
      || (rx_evt.in_header
      && (rx_evt.header_timeout || rx_evt.synch_corrupt));
    set_v[BIT_NOISE] = rx_ok && rx_evt.noise && !slave;
    set_v[BIT_FRAME_ERR] = real_frame;
    set_v[BIT_PARITY_ERR] = rx_ok && rx_evt.id_parity_bad
      && ctrl_q[CTL_PARITY_CHECK_EN];
  end

  // Clear terms: armed flags go on the matching data access
  always_comb
  begin
    clr_v = 8'h00;
    clr_v[BIT_TX_EMPTY] = data_wr && armed_q[BIT_TX_EMPTY];
    clr_v[BIT_TX_DONE] = data_wr && armed_q[BIT_TX_DONE];
    clr_v[BIT_RX_FULL] = data_rd && armed_q[BIT_RX_FULL];
    clr_v[BIT_IDLE] = data_rd && armed_q[BIT_IDLE];
    // Held while the block sits in the synch field state
    clr_v[BIT_HDR_ERR] = data_rd && armed_q[BIT_HDR_ERR]
      && !ctrl_q[CTL_SYNCH_STATE];
    clr_v[BIT_NOISE] = data_rd && armed_q[BIT_NOISE];
    clr_v[BIT_FRAME_ERR] = data_rd && armed_q[BIT_FRAME_ERR];
    clr_v[BIT_PARITY_ERR] = (data_rd || data_wr)
      && armed_q[BIT_PARITY_ERR];
  end

  // Status flags; a set in the clear cycle wins
  always_ff @(posedge mclk)
  begin
    if (reset)
      status_q <= STATUS_RESET;
    else
      status_q <= (status_q & ~clr_v) | set_v;
  end

  // Snapshot of flags seen at the status access
  always_ff @(posedge mclk)
  begin
    if (reset)
      armed_q <= 8'h00;
    else if (status_acc)
      armed_q <= status_q;
    else if (data_rd || data_wr)
      armed_q <= 8'h00;
  end

  // Idle rearms only after a fresh received character
  always_ff @(posedge mclk)
  begin
    if (reset)
      idle_block_q <= 1'b0;
    else if (set_v[BIT_RX_FULL])
      idle_block_q <= 1'b0;
    else if (set_v[BIT_IDLE])
      idle_block_q <= 1'b1;
  end

  // Break report when header detect method is zero
  always_ff @(posedge mclk)
  begin
    if (reset)
      hdr_flag_q <= 1'b0;
    else if (rx_evt.rx_done && rx_evt.rx_is_break && !hunt_drop
      && !ctrl_q[CTL_HDR_DETECT_METHOD])
      hdr_flag_q <= 1'b1;
    else if (data_rd)
      hdr_flag_q <= 1'b0;
  end
  assign header_detect_flag = hdr_flag_q;

  // Control register; mute leaves by break or identifier
  always_ff @(posedge mclk)
  begin
    if (reset)
      ctrl_q <= CTRL_RESET;
    else if (wr && addr == ADDR_CTRL)
      ctrl_q <= wdata;
    else if (lin_mode && slave && mute && !hunt_drop
      && (ctrl_q[CTL_HDR_DETECT_METHOD] ? rx_evt.id_detected
      : (rx_evt.rx_done && rx_evt.rx_is_break)))
      ctrl_q[CTL_RX_MUTE] <= 1'b0;
  end

  // Interrupt enables, laid out as the status bits
  always_ff @(posedge mclk)
  begin
    if (reset)
      irq_en_q <= IRQ_EN_RESET;
    else if (wr && addr == ADDR_IRQ_EN)
      irq_en_q <= wdata;
  end

  // Data port: received byte captured, written byte handed on
  always_ff @(posedge mclk)
  begin
    if (reset)
      data_q <= 8'h00;
    else if (set_v[BIT_RX_FULL])
      data_q <= rx_byte;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      tx_byte <= 8'h00;
      tx_load <= 1'b0;
    end
    else
    begin
      tx_load <= data_wr;
      if (data_wr)
        tx_byte <= wdata;
    end
  end

  // Read data one cycle after the strobe, zero when idle or unmapped
  always_ff @(posedge mclk)
  begin
    if (reset)
      rdata_q <= 8'h00;
    else if (!rd)
      rdata_q <= 8'h00;
    else if (addr == ADDR_STATUS)
      rdata_q <= status_q;
    else if (addr == ADDR_DATA)
      rdata_q <= data_q;
    else if (addr == ADDR_CTRL)
      rdata_q <= ctrl_q;
    else if (addr == ADDR_IRQ_EN)
      rdata_q <= irq_en_q;
    else
      rdata_q <= 8'h00;
  end
  assign rdata = rdata_q;

  // Level interrupt; rx enable covers header error too, noise never
  always_ff @(posedge mclk)
  begin
    if (reset)
      irq <= 1'b0;
    else
      irq <= |(status_q & irq_en_q & 8'hfb)
        || (status_q[BIT_HDR_ERR] && irq_en_q[BIT_RX_FULL]);
  end

endmodule // lin_status_flags
`default_nettype wire

// ---- tb/lin_bus_model.sv ----
// Bus side model: bit timing and receive line level
`timescale 1ns/100ps
`default_nettype none
module lin_bus_model
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Dominant request from the bench
  input wire logic dom,
  // Towards the block
  output logic bit_tick,
  output logic rx_pin
);
  logic [1:0] div_q;
  // Four clock bit time keeps hunts short
  always_ff @(posedge mclk)
  begin
    if (reset)
      div_q <= 2'h0;
    else
      div_q <= div_q + 2'h1;
  end
  // Line pulled up unless a node pulls it low
  assign bit_tick = (div_q == 2'h3);
  assign rx_pin = ~dom;
endmodule // lin_bus_model
`default_nettype wire

// ---- tb/lin_flags_monitor.sv ----
// Port checker of the LIN status flag block
`timescale 1ns/100ps
`default_nettype none
module lin_flags_monitor
  import lin_flags_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // Engine side
  input wire tx_evt_s tx_evt,
  input wire rx_evt_s rx_evt,
  input wire logic bit_tick,
  input wire logic rx_pin,
  input wire logic [7:0] tx_byte,
  input wire logic tx_load,
  input wire logic rx_discard,
  input wire logic header_detect_flag,
  input wire logic irq
);
  logic [3:0] dom_q;
  logic disc_q;
  logic ev;
  // Hunt spends its first cycle arming, so that cycle never counts
  always_ff @(posedge mclk)
  begin
    if (reset)
      disc_q <= 1'b0;
    else
      disc_q <= rx_discard;
  end
  // Dominant ticks seen while bits are dropped
  always_ff @(posedge mclk)
  begin
    if (reset || !rx_discard || !disc_q || (bit_tick && rx_pin))
      dom_q <= 4'h0;
    else if (bit_tick && dom_q != 4'hf)
      dom_q <= dom_q + 4'h1;
  end
  // Any engine activity
  assign ev = (|tx_evt) || (|rx_evt);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  a_status_reset: assert property (
    rd && addr == ADDR_STATUS && $past(reset, 2) |=> rdata == STATUS_RESET)
    else $error("status after reset wrong");
  a_hunt_end: assert property (
    dom_q == HOTPLUG_BITS |-> ##[0:1] !rx_discard)
    else $error("hunt did not end");
  a_irq_cause: assert property (
    $rose(irq) |-> $past(ev) || $past(ev, 2) || $past(wr) || $past(wr, 2))
    else $error("irq rose without cause");
  a_irq_drop: assert property (
    $fell(irq) |-> $past(wr || rd) || $past(wr || rd, 2))
    else $error("irq fell without access");
  a_break_flag: assert property (
    $rose(header_detect_flag) |-> $past(rx_evt.rx_is_break))
    else $error("break flag without break");
  a_load_write: assert property (
    tx_load == $past(wr && addr == ADDR_DATA))
    else $error("tx load mistimed");
  a_byte_write: assert property (
    wr && addr == ADDR_DATA |=> tx_byte == $past(wdata))
    else $error("tx byte wrong");
  a_rdata_quiet: assert property (
    !$past(rd) |-> rdata == 8'h00)
    else $error("rdata without read");
endmodule // lin_flags_monitor
`default_nettype wire

// ---- tb/testbench.sv ----
// Bench for the LIN status flag block
`timescale 1ns/100ps
`default_nettype none
module testbench
  import lin_flags_pkg::*;
;
  logic mclk, reset, wr, rd, dom, bit_tick, rx_pin, tx_load, rx_discard;
  logic hdf, irq;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, rx_byte, tx_byte, got;
  tx_evt_s tx_evt;
  rx_evt_s rx_evt;
  int miscompares, n_checks;
  // Block under test and the bus it faces
  lin_status_flags DUT (.mclk(mclk), .reset(reset), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .tx_evt(tx_evt),
    .rx_evt(rx_evt), .rx_byte(rx_byte), .bit_tick(bit_tick),
    .rx_pin(rx_pin), .tx_byte(tx_byte), .tx_load(tx_load),
    .rx_discard(rx_discard), .header_detect_flag(hdf), .irq(irq));
  lin_bus_model bus (.mclk(mclk), .reset(reset), .dom(dom),
    .bit_tick(bit_tick), .rx_pin(rx_pin));
  // 40 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic chk(input string n, input logic [7:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  // Read data lands one cycle after the strobe
  task automatic rreg(input logic [3:0] a);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask
  task automatic st(input logic [7:0] e);
    rreg(ADDR_STATUS);
    chk("status", e, got);
  endtask
  task automatic irqc(input logic e);
    repeat (2) @(posedge mclk);
    #1 chk("irq", {7'h00, e}, {7'h00, irq});
  endtask
  // Event pulse: tx bits 13..11, rx bits 10..0
  task automatic ev(input logic [13:0] v);
    @(posedge mclk);
    tx_evt <= v[13:11];
    rx_evt <= v[10:0];
    @(posedge mclk);
    tx_evt <= 3'h0;
    rx_evt <= 11'h000;
    repeat (2) @(posedge mclk);
  endtask
  task automatic t_tx;
    rreg(4'hf);
    chk("unmapped", 8'h00, got);
    wreg(ADDR_DATA, 8'ha5);
    st(8'h00);
    ev(14'h2000);
    st(8'h80);
    ev(14'h1000);
    st(8'h80);
    ev(14'h1800);
    st(8'hc0);
    wreg(ADDR_IRQ_EN, 8'h40);
    irqc(1'b1);
    wreg(ADDR_IRQ_EN, 8'h80);
    irqc(1'b1);
    st(8'hc0);
    wreg(ADDR_DATA, 8'h5a);
    irqc(1'b0);
    wreg(ADDR_IRQ_EN, 8'h20);
  endtask
  task automatic t_rx;
    ev(14'h0400);
    st(8'h20);
    irqc(1'b1);
    rreg(ADDR_DATA);
    chk("data", 8'h3c, got);
    st(8'h00);
    ev(14'h0400);
    ev(14'h0400);
    st(8'h28);
    rreg(ADDR_DATA);
    ev(14'h0018);
    st(8'h08);
    irqc(1'b1);
    rreg(ADDR_DATA);
    st(8'h00);
    ev(14'h0002);
    st(8'h10);
    rreg(ADDR_DATA);
    ev(14'h0002);
    st(8'h00);
    ev(14'h0400);
    st(8'h20);
    rreg(ADDR_DATA);
    ev(14'h0002);
    st(8'h10);
    rreg(ADDR_DATA);
  endtask
  task automatic t_err;
    wreg(ADDR_CTRL, 8'h01);
    ev(14'h0440);
    st(8'h24);
    rreg(ADDR_DATA);
    wreg(ADDR_CTRL, 8'h03);
    ev(14'h0580);
    st(8'h22);
    rreg(ADDR_DATA);
    ev(14'h0700);
    rreg(ADDR_STATUS);
    chk("frame", 8'h00, got & 8'h02);
    chk("break", 8'h01, {7'h00, hdf});
    rreg(ADDR_DATA);
    wreg(ADDR_CTRL, 8'h11);
    ev(14'h0420);
    st(8'h21);
    rreg(ADDR_DATA);
  endtask
  task automatic t_hot;
    wreg(ADDR_CTRL, 8'h07);
    dom <= 1'b1;
    repeat (20) @(posedge mclk);
    dom <= 1'b0;
    repeat (8) @(posedge mclk);
    #1 chk("discard", 8'h01, {7'h00, rx_discard});
    ev(14'h0580);
    st(8'h00);
    @(posedge mclk);
    dom <= 1'b1;
    repeat (52) @(posedge mclk);
    #1 chk("discard", 8'h00, {7'h00, rx_discard});
    // Hunt over but still muted: only mute can drop the fault now
    ev(14'h0580);
    st(8'h00);
    ev(14'h0700);
    rreg(ADDR_CTRL);
    chk("ctrl", 8'h03, got);
    rreg(ADDR_DATA);
    // Identifier method: a break keeps mute, an identifier ends it
    wreg(ADDR_CTRL, 8'h0f);
    repeat (52) @(posedge mclk);
    ev(14'h0700);
    rreg(ADDR_CTRL);
    chk("ctrl", 8'h0f, got);
    chk("break", 8'h00, {7'h00, hdf});
    ev(14'h0001);
    rreg(ADDR_CTRL);
    chk("ctrl", 8'h0b, got);
  endtask
  task automatic end_sim;
    if (miscompares == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Watchdog well beyond the run length
  initial
  begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    end_sim();
  end
  // Reset, then the scenarios
  initial
  begin
    {reset, wr, rd, dom, addr, wdata} = {4'h8, 4'h0, 8'h00};
    {tx_evt, rx_evt, rx_byte} = {14'h0000, 8'h3c};
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    st(8'hc0);
    t_tx();
    t_rx();
    t_err();
    t_hot();
    end_sim();
  end
endmodule // testbench
bind lin_status_flags lin_flags_monitor mon (.mclk(mclk), .reset(reset),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .tx_evt(tx_evt), .rx_evt(rx_evt), .bit_tick(bit_tick), .rx_pin(rx_pin),
  .tx_byte(tx_byte), .tx_load(tx_load), .rx_discard(rx_discard),
  .header_detect_flag(header_detect_flag), .irq(irq));
`default_nettype wire
